// File: hw/gerf_defs.vh
// constants shared by the generic event route fabric
`ifndef GERF_DEFS_VH
`define GERF_DEFS_VH
// channel select value that means "not connected"
`define GERF_CH_NONE        0
// subscribers a splitter channel accepts
`define GERF_SPL_FANOUT     2
// internal wake-up subscriber ports and transfer controller generic ports
`define GERF_WAKE_PORTS     2
`define GERF_XFER_PORTS     2
// low-power bus clock cycles of one four-way handshake, at the least
`define GERF_HS_CYCLES      4
// channel count descriptor layout
`define GERF_DESC_P2P_LSB   0
`define GERF_DESC_SPL_LSB   8
`define GERF_DESC_FIELD_W   8
`define GERF_DESC_W         16
`define GERF_DESC_RESET     16'h0000
`endif

// File: hw/gerf_chan.v
// one generic route channel: four-way handshake between its publisher and subscribers
`default_nettype none
`include "gerf_defs.vh"
module gerf_chan #(
    parameter NSUB = 4
) (
    input  wire            clock,     // low-power bus clock
    input  wire            rst,       // async reset, active high
    input  wire            pub_req,   // request level from the publisher
    input  wire [NSUB-1:0] sub_mask,  // subscribers connected to this channel
    input  wire [NSUB-1:0] sub_ack,   // acknowledge levels of all subscribers
    output reg             sub_req_r, // request level toward subscribers
    output reg             pub_ack_r  // acknowledge toward publisher, clears its pending request
);
    // ------------------------------------------------------------
    // handshake states
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_REQ  = 4'h2;
    localparam [3:0] ST_HOLD = 4'h4;
    localparam [3:0] ST_DROP = 4'h8;

    reg  [3:0] state_r;
    reg  [3:0] state_nxt;
    reg        sub_req_nxt;
    reg        pub_ack_nxt;
    wire       all_ack  = &(sub_ack | ~sub_mask);
    wire       any_ack  = |(sub_ack & sub_mask);

    always @* begin
        state_nxt   = state_r;
        sub_req_nxt = sub_req_r;
        pub_ack_nxt = pub_ack_r;
        case (state_r)
            ST_IDLE: begin
                if (pub_req) begin          // [RQ16] step 1: request raised
                    state_nxt   = ST_REQ;
                    sub_req_nxt = 1'b1;     // [RQ13]
                end
            end
            ST_REQ: begin
                if (all_ack) begin          // [RQ16] step 2: acknowledged
                    state_nxt   = ST_HOLD;
                    pub_ack_nxt = 1'b1;     // [RQ4]
                end
            end
            ST_HOLD: begin
                if (!pub_req) begin         // [RQ16] step 3: request dropped
                    state_nxt   = ST_DROP;
                    sub_req_nxt = 1'b0;
                    pub_ack_nxt = 1'b0;
                end
            end
            ST_DROP: begin
                if (!any_ack) begin         // [RQ16] step 4: drop acknowledged
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt   = ST_IDLE;
                sub_req_nxt = 1'b0;
                pub_ack_nxt = 1'b0;
            end
        endcase
    end

    // requests seen outside idle are never queued, so a second one is lost
    always @(posedge clock or posedge rst) begin // [RQ17]
        if (rst) begin
            state_r   <= ST_IDLE;
            sub_req_r <= 1'b0;
            pub_ack_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            sub_req_r <= sub_req_nxt;
            pub_ack_r <= pub_ack_nxt;
        end
    end
endmodule // gerf_chan
`default_nettype wire

// File: hw/gerf_fabric.v
// generic event route fabric: fixed routes, generic channels and subscription arbitration
//
// Functional notes
// [RQ1] fabric keeps no configuration registers itself
// [RQ2] processor gets two generic subscriber ports
// [RQ3] wake-up port captures channel, raises generic interrupt
// [RQ4] handshake acknowledge clears publisher pending request
// [RQ5] software sees only the subscriber port firing
// [RQ6] transfer controller has two generic subscriber ports
// [RQ7] publisher select value N publishes on N
// [RQ8] subscriber select value N listens on N
// [RQ9] software keeps one publisher per channel
// [RQ10] fixed interrupts pass with no fabric setup
// [RQ11] several fixed transfer triggers per peripheral
// [RQ12] triggers without register set pass the same
// [RQ13] channel events act in hardware, no processor
// [RQ14] each port configured on its own
// [RQ15] read-only descriptor of channel counts
// [RQ16] four-step request/acknowledge handshake per transfer
// [RQ17] request during unfinished handshake is dropped
// [RQ18] point-to-point channel refuses a second subscriber
// [RQ19] splitter takes two, blocks until both leave
`default_nettype none
`include "gerf_defs.vh"
module gerf_fabric #(
    parameter N_PUB  = 4,  // publisher ports
    parameter N_SUB  = 4,  // external subscriber ports, the first two belong to the transfer controller
    parameter N_P2P  = 4,  // point-to-point channels, numbered 1..N_P2P
    parameter N_SPL  = 2,  // splitter channels, numbered after them
    parameter CW     = 4,  // channel select width
    parameter N_IRQ  = 8,  // fixed interrupt routes
    parameter N_TRIG = 4   // fixed transfer trigger routes
) (
    input  wire                               clock,                           // low-power bus clock
    input  wire                               rst,                             // async reset, active high
    input  wire [N_PUB*CW-1:0]                publisher_channel_select,        // channel per publisher, 0 = none
    input  wire [N_PUB-1:0]                   pub_req,                         // publisher pending request levels
    output reg  [N_PUB-1:0]                   pub_ack_r,                       // handshake acknowledge per publisher
    input  wire [N_SUB*CW-1:0]                subscriber_channel_select,       // channel per external subscriber
    input  wire [N_SUB-1:0]                   sub_ack,                         // external subscriber acknowledges
    output reg  [N_SUB-1:0]                   sub_req_r,                       // event request per external subscriber
    output reg  [N_SUB-1:0]                   sub_connected_r,                 // selection accepted
    input  wire [`GERF_WAKE_PORTS*CW-1:0]     wakeup_channel_select,           // wake-up controller subscriber selects
    output reg  [`GERF_WAKE_PORTS-1:0]        generic_subscriber_interrupt_r,  // one-cycle processor interrupt
    output reg  [`GERF_WAKE_PORTS-1:0]        wakeup_connected_r,              // wake-up selection accepted
    input  wire [N_IRQ-1:0]                   fixed_irq,                       // masked status of peripherals
    output reg  [N_IRQ-1:0]                   cpu_irq_r,                       // fixed interrupts to processor
    input  wire [N_TRIG-1:0]                  fixed_trig_req,                  // fixed transfer trigger requests
    output reg  [N_TRIG-1:0]                  fixed_trig_ack_r,                // acknowledges back to peripherals
    output reg  [N_TRIG-1:0]                  xfer_trig_req_r,                 // fixed triggers to transfer controller
    input  wire [N_TRIG-1:0]                  xfer_trig_ack,                   // transfer controller acknowledges
    output reg  [`GERF_DESC_W-1:0]            channel_count_descriptor_r       // read-only channel counts
);
    localparam NCH = N_P2P + N_SPL;
    localparam TS  = `GERF_WAKE_PORTS + N_SUB; // wake-up ports first

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function [CW-1:0] chan_id;
        input integer c;
        reg [31:0] t;
        begin
            t       = c + 1;
            chan_id = t[CW-1:0];
        end
    endfunction

    function chan_valid;
        input [CW-1:0] sel;
        begin
            chan_valid = (sel != `GERF_CH_NONE) && ({{(32-CW){1'b0}}, sel} <= NCH);
        end
    endfunction

    // ------------------------------------------------------------
    // fixed routes
    // ------------------------------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_irq_r        <= {N_IRQ{1'b0}};
            xfer_trig_req_r  <= {N_TRIG{1'b0}};
            fixed_trig_ack_r <= {N_TRIG{1'b0}};
        end else begin
            cpu_irq_r        <= fixed_irq;      // [RQ10]
            xfer_trig_req_r  <= fixed_trig_req; // [RQ11] [RQ12]
            fixed_trig_ack_r <= xfer_trig_ack;
        end
    end

    // ------------------------------------------------------------
    // descriptor
    // ------------------------------------------------------------
    localparam [`GERF_DESC_FIELD_W-1:0] P2P_CNT = N_P2P;
    localparam [`GERF_DESC_FIELD_W-1:0] SPL_CNT = N_SPL;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            channel_count_descriptor_r <= `GERF_DESC_RESET;
        end else begin
            channel_count_descriptor_r[`GERF_DESC_P2P_LSB +: `GERF_DESC_FIELD_W] <= P2P_CNT; // [RQ15]
            channel_count_descriptor_r[`GERF_DESC_SPL_LSB +: `GERF_DESC_FIELD_W] <= SPL_CNT; // [RQ15]
        end
    end

    // ------------------------------------------------------------
    // subscription arbitration
    // ------------------------------------------------------------
    wire [TS*CW-1:0] all_sel = {subscriber_channel_select, wakeup_channel_select}; // [RQ1] [RQ2] [RQ6] [RQ14]
    reg  [TS-1:0]    gnt_r;
    reg  [TS-1:0]    gnt_nxt;
    reg  [TS*CW-1:0] gch_r;
    reg  [TS*CW-1:0] gch_nxt;
    reg  [N_SPL-1:0] lock_r;
    reg  [N_SPL-1:0] lock_nxt;
    reg  [N_SPL-1:0] lock_eff;
    reg  [7:0]       cnt [0:NCH-1];
    reg  [CW-1:0]    sel_v;
    integer          s;
    integer          c;
    integer          k;

    always @* begin
        gnt_nxt  = gnt_r;
        gch_nxt  = gch_r;
        lock_eff = lock_r;
        lock_nxt = lock_r;
        sel_v    = {CW{1'b0}};
        k        = 0;
        for (c = 0; c < NCH; c = c + 1) begin
            cnt[c] = 8'h00;
        end
        // a changed select first leaves the old channel
        for (s = 0; s < TS; s = s + 1) begin
            if (all_sel[s*CW +: CW] != gch_r[s*CW +: CW]) begin
                gnt_nxt[s]            = 1'b0;
                gch_nxt[s*CW +: CW]   = `GERF_CH_NONE;
            end
        end
        for (s = 0; s < TS; s = s + 1) begin
            if (gnt_nxt[s]) begin
                k      = gch_nxt[s*CW +: CW] - 1;
                cnt[k] = cnt[k] + 8'h01;
            end
        end
        for (c = 0; c < N_SPL; c = c + 1) begin
            if (cnt[N_P2P + c] == 8'h00) begin
                lock_eff[c] = 1'b0;         // [RQ19]
            end
        end
        // lower port index wins when two ask in the same cycle
        for (s = 0; s < TS; s = s + 1) begin
            sel_v = all_sel[s*CW +: CW];
            if (!gnt_nxt[s] && chan_valid(sel_v)) begin
                k = sel_v - 1;
                if (k < N_P2P) begin
                    if (cnt[k] == 8'h00) begin // [RQ18]
                        gnt_nxt[s]          = 1'b1;
                        gch_nxt[s*CW +: CW] = sel_v; // [RQ8]
                        cnt[k]              = cnt[k] + 8'h01;
                    end
                end else if (!lock_eff[k - N_P2P] && cnt[k] < `GERF_SPL_FANOUT) begin // [RQ19]
                    gnt_nxt[s]          = 1'b1;
                    gch_nxt[s*CW +: CW] = sel_v; // [RQ8]
                    cnt[k]              = cnt[k] + 8'h01;
                end
            end
        end
        for (c = 0; c < N_SPL; c = c + 1) begin
            lock_nxt[c] = lock_eff[c] | (cnt[N_P2P + c] == `GERF_SPL_FANOUT); // [RQ19]
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            gnt_r  <= {TS{1'b0}};
            gch_r  <= {(TS*CW){1'b0}};
            lock_r <= {N_SPL{1'b0}};
        end else begin
            gnt_r  <= gnt_nxt;
            gch_r  <= gch_nxt;
            lock_r <= lock_nxt;
        end
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    reg  [NCH-1:0]    ch_evt;
    reg  [NCH*TS-1:0] ch_mask;
    wire [NCH-1:0]    ch_sreq;
    wire [NCH-1:0]    ch_pack;
    reg  [`GERF_WAKE_PORTS-1:0] wk_ack_r;
    wire [TS-1:0]     all_ack = {sub_ack, wk_ack_r};
    // each process keeps its own loop indices, shared ones would retrigger each other
    integer           ci;
    integer           si;

    always @* begin
        ch_evt  = {NCH{1'b0}};
        ch_mask = {(NCH*TS){1'b0}};
        for (ci = 0; ci < NCH; ci = ci + 1) begin
            for (si = 0; si < N_PUB; si = si + 1) begin
                if (publisher_channel_select[si*CW +: CW] == chan_id(ci)) begin
                    ch_evt[ci] = ch_evt[ci] | pub_req[si]; // [RQ7] [RQ9]
                end
            end
            for (si = 0; si < TS; si = si + 1) begin
                ch_mask[ci*TS + si] = gnt_r[si] && (gch_r[si*CW +: CW] == chan_id(ci));
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_chan
            gerf_chan #(
                .NSUB (TS)
            ) u_chan (
                .clock     (clock),
                .rst       (rst),
                .pub_req   (ch_evt[g]),
                .sub_mask  (ch_mask[g*TS +: TS]),
                .sub_ack   (all_ack),
                .sub_req_r (ch_sreq[g]),
                .pub_ack_r (ch_pack[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // port side of the channels
    // ------------------------------------------------------------
    reg [N_PUB-1:0] pub_ack_nxt;
    reg [TS-1:0]    sreq_nxt;
    reg [CW-1:0]    psel_v;
    integer         ps;
    integer         pc;

    always @* begin
        pub_ack_nxt = {N_PUB{1'b0}};
        sreq_nxt    = {TS{1'b0}};
        psel_v      = {CW{1'b0}};
        for (ps = 0; ps < N_PUB; ps = ps + 1) begin
            psel_v = publisher_channel_select[ps*CW +: CW];
            for (pc = 0; pc < NCH; pc = pc + 1) begin
                if (psel_v == chan_id(pc)) begin
                    pub_ack_nxt[ps] = ch_pack[pc]; // [RQ4]
                end
            end
        end
        for (ps = 0; ps < TS; ps = ps + 1) begin
            for (pc = 0; pc < NCH; pc = pc + 1) begin
                if (ch_mask[pc*TS + ps]) begin
                    sreq_nxt[ps] = ch_sreq[pc]; // [RQ13]
                end
            end
        end
    end

    // the interrupt pulse is the only trace software gets of a generic cause
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pub_ack_r                      <= {N_PUB{1'b0}};
            sub_req_r                      <= {N_SUB{1'b0}};
            sub_connected_r                <= {N_SUB{1'b0}};
            wakeup_connected_r             <= {`GERF_WAKE_PORTS{1'b0}};
            wk_ack_r                       <= {`GERF_WAKE_PORTS{1'b0}};
            generic_subscriber_interrupt_r <= {`GERF_WAKE_PORTS{1'b0}};
        end else begin
            pub_ack_r                      <= pub_ack_nxt;
            sub_req_r                      <= sreq_nxt[TS-1:`GERF_WAKE_PORTS];
            sub_connected_r                <= gnt_r[TS-1:`GERF_WAKE_PORTS];
            wakeup_connected_r             <= gnt_r[`GERF_WAKE_PORTS-1:0];
            wk_ack_r                       <= sreq_nxt[`GERF_WAKE_PORTS-1:0]; // [RQ3]
            generic_subscriber_interrupt_r <= sreq_nxt[`GERF_WAKE_PORTS-1:0] & ~wk_ack_r; // [RQ3] [RQ5]
        end
    end
endmodule // gerf_fabric
`default_nettype wire

// File: tb/gerf_fabric_assertions.sv
// assertion checker for the generic event route fabric
`default_nettype none
module gerf_fabric_chk #(
    parameter N_PUB  = 4,
    parameter N_SUB  = 4,
    parameter N_P2P  = 4,
    parameter N_SPL  = 2,
    parameter CW     = 4,
    parameter N_IRQ  = 8,
    parameter N_TRIG = 4
) (
    input wire logic                clock,                          // bus clock
    input wire logic                rst,                            // async reset
    input wire logic [N_PUB-1:0]    pub_req,                        // publisher requests
    input wire logic [N_PUB-1:0]    pub_ack_r,                      // publisher acks
    input wire logic [N_SUB*CW-1:0] subscriber_channel_select,      // subscriber selects
    input wire logic [2*CW-1:0]     wakeup_channel_select,          // wake-up selects
    input wire logic [N_SUB-1:0]    sub_req_r,                      // subscriber requests
    input wire logic [N_SUB-1:0]    sub_connected_r,                // subscriber grants
    input wire logic [1:0]          wakeup_connected_r,             // wake-up grants
    input wire logic [1:0]          generic_subscriber_interrupt_r, // interrupt pulses
    input wire logic [N_IRQ-1:0]    fixed_irq,                      // fixed irq in
    input wire logic [N_IRQ-1:0]    cpu_irq_r,                      // fixed irq out
    input wire logic [N_TRIG-1:0]   fixed_trig_req,                 // trigger in
    input wire logic [N_TRIG-1:0]   xfer_trig_req_r,                // trigger out
    input wire logic [N_TRIG-1:0]   xfer_trig_ack,                  // trigger ack in
    input wire logic [N_TRIG-1:0]   fixed_trig_ack_r,               // trigger ack out
    input wire logic [15:0]         channel_count_descriptor_r      // channel counts
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam NP = N_SUB + 2;
    localparam logic [7:0] P8 = N_P2P;
    localparam logic [7:0] S8 = N_SPL;
    logic [NP*CW-1:0] sel, sd1, sd2;
    logic [NP-1:0]    con;
    logic             over_p2p, over_spl;
    int               n;
    assign sel = {subscriber_channel_select, wakeup_channel_select};
    assign con = {sub_connected_r, wakeup_connected_r};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sd1 <= '0;
            sd2 <= '0;
        end else begin
            sd1 <= sel;
            sd2 <= sd1;
        end
    end
    // subscribers per channel, counting only ports whose select has settled
    always_comb begin
        over_p2p = 1'b0;
        over_spl = 1'b0;
        for (int ch = 1; ch <= N_P2P + N_SPL; ch++) begin
            n = 0;
            for (int i = 0; i < NP; i++) begin
                if (con[i] && sel[i*CW+:CW] == ch && sd1[i*CW+:CW] == ch && sd2[i*CW+:CW] == ch) begin
                    n++;
                end
            end
            if (ch <= N_P2P && n > 1) over_p2p = 1'b1;
            if (ch > N_P2P && n > 2) over_spl = 1'b1;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    property p_irq_pass;
        !$past(rst) |-> cpu_irq_r == $past(fixed_irq);
    endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("fixed irq not passed");
    property p_trig_pass;
        !$past(rst) |-> xfer_trig_req_r == $past(fixed_trig_req);
    endproperty
    a_trig_pass: assert property (p_trig_pass) else $error("fixed trigger not passed");
    property p_trig_ack;
        !$past(rst) |-> fixed_trig_ack_r == $past(xfer_trig_ack);
    endproperty
    a_trig_ack: assert property (p_trig_ack) else $error("trigger ack not passed");
    property p_desc;
        !$past(rst) |-> channel_count_descriptor_r == {S8, P8};
    endproperty
    a_desc: assert property (p_desc) else $error("channel counts wrong");
    property p_pulse;
        generic_subscriber_interrupt_r != 2'h0 |=> (generic_subscriber_interrupt_r & $past(generic_subscriber_interrupt_r)) == 2'h0;
    endproperty
    a_pulse: assert property (p_pulse) else $error("interrupt longer than a cycle");
    property p_p2p;
        !over_p2p;
    endproperty
    a_p2p: assert property (p_p2p) else $error("second subscriber on point channel");
    property p_spl;
        !over_spl;
    endproperty
    a_spl: assert property (p_spl) else $error("third subscriber on splitter");
    property p_req_cause;
        (sub_req_r & ~$past(sub_req_r)) != '0 |-> $past(pub_req, 2) != '0;
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("subscriber request without publisher");
    property p_ack_cause;
        (pub_ack_r & ~$past(pub_ack_r) & ~$past(pub_req)) == '0;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without pending request");
    for (genvar p = 0; p < N_PUB; p++) begin : g_pub
        property p_ack_fall;
            $fell(pub_req[p]) && pub_ack_r[p] |-> ##1 pub_ack_r[p] ##1 !pub_ack_r[p];
        endproperty
        a_ack_fall: assert property (p_ack_fall) else $error("ack drop timing wrong");
    end
endmodule // gerf_fabric_chk
bind gerf_fabric gerf_fabric_chk #(.N_PUB(N_PUB), .N_SUB(N_SUB), .N_P2P(N_P2P), .N_SPL(N_SPL), .CW(CW),
    .N_IRQ(N_IRQ), .N_TRIG(N_TRIG)) u_chk (.clock, .rst, .pub_req, .pub_ack_r, .subscriber_channel_select,
    .wakeup_channel_select, .sub_req_r, .sub_connected_r, .wakeup_connected_r, .generic_subscriber_interrupt_r,
    .fixed_irq, .cpu_irq_r, .fixed_trig_req, .xfer_trig_req_r, .xfer_trig_ack, .fixed_trig_ack_r,
    .channel_count_descriptor_r);
`default_nettype wire

// File: tb/gerf_peer_model.sv
// subscriber and transfer controller model on the far side of the fabric
`default_nettype none
module gerf_peer_model #(
    parameter N_SUB  = 4,
    parameter N_TRIG = 4
) (
    input  wire logic              clock,           // bus clock
    input  wire logic              rst,             // async reset
    input  wire logic [N_SUB-1:0]  sub_req_r,       // requests from fabric
    input  wire logic [3:0]        ack_delay,       // extra cycles before each ack edge
    output var  logic [N_SUB-1:0]  sub_ack,         // acknowledges to fabric
    input  wire logic [N_TRIG-1:0] xfer_trig_req_r, // fixed triggers
    output var  logic [N_TRIG-1:0] xfer_trig_ack    // trigger acknowledges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_r [N_SUB];
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sub_ack <= '0;
            xfer_trig_ack <= '0;
            for (int i = 0; i < N_SUB; i++) wait_r[i] <= 4'h0;
        end else begin
            xfer_trig_ack <= xfer_trig_req_r;
            for (int i = 0; i < N_SUB; i++) begin
                if (sub_req_r[i] == sub_ack[i]) begin
                    wait_r[i] <= 4'h0;
                end else if (wait_r[i] >= ack_delay) begin
                    sub_ack[i] <= sub_req_r[i];
                    wait_r[i] <= 4'h0;
                end else begin
                    wait_r[i] <= wait_r[i] + 4'h1;
                end
            end
        end
    end
endmodule // gerf_peer_model
`default_nettype wire

// File: tb/gerf_fabric_bench.sv
// self-checking testbench of the generic event route fabric
`default_nettype none
module gerf_fabric_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst;
    logic [15:0] psel, ssel, desc, lf;
    logic [7:0]  wsel, firq, cirq;
    logic [3:0]  preq, pack, sreq, sack, scon, ftreq, ftack, xreq, xack, dly;
    logic [1:0]  gsi, wcon;
    logic [3:0]  notes [5][$];
    logic [3:0]  seen [5];
    logic [3:0]  prev [5];
    logic [3:0]  ex;
    string       nm [5] = '{"connected", "wakeup", "subreq", "interrupt", "puback"};
    int          n_mismatch, checks_done, cyc;
    gerf_fabric i_dut (.clock(clock), .rst(rst), .publisher_channel_select(psel), .pub_req(preq),
        .pub_ack_r(pack), .subscriber_channel_select(ssel), .sub_ack(sack), .sub_req_r(sreq),
        .sub_connected_r(scon), .wakeup_channel_select(wsel), .generic_subscriber_interrupt_r(gsi),
        .wakeup_connected_r(wcon), .fixed_irq(firq), .cpu_irq_r(cirq), .fixed_trig_req(ftreq),
        .fixed_trig_ack_r(ftack), .xfer_trig_req_r(xreq), .xfer_trig_ack(xack), .channel_count_descriptor_r(desc));
    gerf_peer_model i_peer (.clock(clock), .rst(rst), .sub_req_r(sreq), .ack_delay(dly), .sub_ack(sack),
        .xfer_trig_req_r(xreq), .xfer_trig_ack(xack));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic note(input int k, input logic [3:0] v);
        notes[k].push_back(v);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // one publisher transfer; again adds a request pulse while the channel is busy
    task automatic hs(input int p, input logic [3:0] sv, input logic [1:0] gv, input bit again);
        int t;
        if (sv != 4'h0) note(2, sv);
        if (gv != 2'h0) note(3, {2'h0, gv});
        note(4, 4'h1 << p);
        @(posedge clock);
        dly <= {1'h0, lf[14:12]};
        preq[p] <= 1'b1;
        t = 0;
        while (pack[p] !== 1'b1 && t < 200) begin
            @(posedge clock);
            t++;
        end
        preq[p] <= 1'b0;
        if (again) begin
            @(posedge clock);
            preq[p] <= 1'b1;
            @(posedge clock);
            preq[p] <= 1'b0;
        end
        tick(12);
    endtask
    task automatic complete_run;
        for (int k = 0; k < 5; k++) begin
            if (notes[k].size() != 0) begin
                n_mismatch++;
                $display("CHECK FAILED %s expected %h seen none", nm[k], notes[k][0]);
            end
        end
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ----------------------------------------
    // rising outputs matched against the notes
    // ----------------------------------------
    always @(negedge clock) begin
        seen[0] = scon;
        seen[1] = {2'h0, wcon};
        seen[2] = sreq;
        seen[3] = {2'h0, gsi};
        seen[4] = pack;
        for (int k = 0; k < 5; k++) begin
            if (!rst && (seen[k] & ~prev[k]) != 4'h0) begin
                checks_done++;
                ex = (notes[k].size() != 0) ? notes[k][0] : 4'hX;
                if (ex !== (seen[k] & ~prev[k])) begin
                    n_mismatch++;
                    $display("CHECK FAILED %s expected %h seen %h", nm[k], ex, seen[k] & ~prev[k]);
                end
                if (notes[k].size() != 0) void'(notes[k].pop_front());
            end
            prev[k] = seen[k];
        end
    end
    always @(posedge clock) begin
        lf <= lfsr(lf);
        firq <= lf[7:0];
        ftreq <= lf[11:8];
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            $display("CHECK FAILED run length expected %0d seen %0d", 2999, cyc);
            complete_run();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        lf = 16'h10A8;
        {psel, ssel, wsel, preq, dly, firq, ftreq} = '0;
        {n_mismatch, checks_done, cyc} = '0;
        tick(20);
        rst <= 1'b0;
        tick(2);
        checks_done++;
        if (desc !== 16'h0204) begin
            n_mismatch++;
            $display("CHECK FAILED descriptor expected %h seen %h", 16'h0204, desc);
        end
        note(0, 4'h1);
        ssel <= 16'h0011;
        tick(8);
        note(0, 4'h2);
        ssel <= 16'h0010;
        tick(8);
        psel <= 16'h0001;
        tick(2);
        hs(0, 4'h2, 2'h0, 1'b1);
        hs(0, 4'h2, 2'h0, 1'b0);
        note(1, 4'h1);
        wsel <= 8'h05;
        tick(6);
        note(0, 4'h4);
        ssel <= 16'h0510;
        tick(6);
        ssel <= 16'h5510;
        tick(6);
        psel <= 16'h0051;
        tick(2);
        hs(1, 4'h4, 2'h1, 1'b0);
        wsel <= 8'h00;
        tick(8);
        note(0, 4'h8);
        ssel <= 16'h5017;
        tick(8);
        note(1, 4'h2);
        wsel <= 8'h20;
        tick(6);
        psel <= 16'h3251;
        tick(2);
        hs(2, 4'h0, 2'h2, 1'b0);
        hs(3, 4'h0, 2'h0, 1'b0);
        tick(10);
        complete_run();
    end
endmodule // gerf_fabric_bench
`default_nettype wire
